// ### hw/tkd_consts.svh
// Purpose: Named constants of the touch-key host command decoder.
// Assumes: Included by the package and by every design file that needs a number.
// Notes: Codes, field positions and timing figures live here and nowhere else.
`ifndef TKD_CONSTS_SVH
`define TKD_CONSTS_SVH

// Command codes and the code groups; every group but the plain one carries a key index in its low bits.
`define TKD_CMD_NULL 8'h00
`define TKD_CMD_CALALL 8'h03
`define TKD_CMD_RESET 8'h04
`define TKD_CMD_STATUS 8'h05
`define TKD_CMD_FIRST 8'h06
`define TKD_CMD_ALLKEYS 8'h07
`define TKD_CMD_ERRALL 8'h0B
`define TKD_CMD_SELFTEST 8'h0C
`define TKD_CMD_DUMP 8'h0D
`define TKD_CMD_EECRC 8'h0E
`define TKD_CMD_LAST 8'h0F
`define TKD_GRP_PLAIN 2'h0
`define TKD_GRP_DIAG 2'h1
`define TKD_GRP_KEYST 2'h2
`define TKD_GRP_CALKEY 2'h3

// Geometry of the key array and of the replies.
`define TKD_NKEYS 24
`define TKD_SETUP_BYTES 100
`define TKD_FIELD_BYTES 7'h03
`define TKD_DIAG_BYTES 7'h05
`define TKD_ONE_BYTE 7'h01
`define TKD_NO_KEY 5'h1F

// General status byte fields.
`define TKD_ST_CAL 0
`define TKD_ST_CALFAIL 1
`define TKD_ST_SYNC 2
`define TKD_ST_SELFTEST 3
`define TKD_ST_LOWSIG 4
`define TKD_ST_COMMS 6

// First-key report fields.
`define TKD_FK_MULTI 7
`define TKD_FK_ERROR 6

// Per-key status fields.
`define TKD_KS_ENABLED 4
`define TKD_KS_DETECT 3
`define TKD_KS_LOWSIG 2
`define TKD_KS_CAL 1
`define TKD_KS_CALFAIL 0

// Checksum: CRC-8, polynomial x^8+x^5+x^4+1, MSB first.
`define TKD_CRC_POLY 8'h31
`define TKD_CRC_INIT 8'h00

// Window for the second copy of a guarded command.
`define TKD_ARM_WINDOW_MS 100
`define TKD_CLK_KHZ 50000

`endif

// ### hw/tkd_pkg.sv
// Purpose: Types and the checksum function of the command decoder.
// Assumes: The constants header sits beside this file.
// Notes: Host software must use the same checksum function.
`include "tkd_consts.svh"

package tkd_pkg;

	// Kind of reply that is being shifted out, one-hot.
	typedef enum logic [11:0] {
		RK_IDLE = 12'h001,
		RK_ACK = 12'h002,
		RK_STATUS = 12'h004,
		RK_FIRST = 12'h008,
		RK_ALL = 12'h010,
		RK_ERR = 12'h020,
		RK_SELF = 12'h040,
		RK_DUMP = 12'h080,
		RK_EECRC = 12'h100,
		RK_LAST = 12'h200,
		RK_DIAG = 12'h400,
		RK_KEYST = 12'h800
	} tkd_rsp_type;

	// Folds one byte into a running CRC-8.
	function automatic logic [7:0] tkd_crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ `TKD_CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

endpackage

// ### hw/tkd_setup_mem.sv
// Purpose: Setup array store with one write port and two registered read ports.
// Assumes: Writes come from the setups loader on the same clock.
// Notes: Port A serves the dump reply, port B the background checksum sweep.
`include "tkd_consts.svh"
module tkd_setup_mem #(
	parameter int DEPTH = `TKD_SETUP_BYTES,
	parameter int AW = 7
) (
	input wire logic clk, // System clock.
	input wire logic wrEn, // Write strobe.
	input wire logic [AW-1:0] wrAddr, // Write address.
	input wire logic [7:0] wrData, // Write data.
	input wire logic [AW-1:0] rdAddrA, // Read address, port A.
	output logic [7:0] rdDataA, // Registered read data, port A.
	input wire logic [AW-1:0] rdAddrB, // Read address, port B.
	output logic [7:0] rdDataB // Registered read data, port B.
);

	logic [7:0] mem [DEPTH];

	// Store a byte when the loader strobes an address inside the array.
	always_ff @(posedge clk) begin
		if (wrEn && (int'(wrAddr) < DEPTH)) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Both reads are registered; out-of-range addresses read as zero.
	always_ff @(posedge clk) begin
		rdDataA <= (int'(rdAddrA) < DEPTH) ? mem[rdAddrA] : 8'h00;
		rdDataB <= (int'(rdAddrB) < DEPTH) ? mem[rdAddrB] : 8'h00;
	end

endmodule // tkd_setup_mem

// ### hw/tkd_decoder.sv
// Purpose: Byte command interpreter behind the serial slave port of a touch-key matrix sensor.
// Assumes: Sensing logic on clk supplies key state; the host clocks the port at mode 0, MSB first.
// Notes: Each exchanged byte returns the next reply byte; pins are double-synchronised.
`include "tkd_consts.svh"
module tkd_decoder
	import tkd_pkg::*;
#(
	parameter int NKEYS = `TKD_NKEYS,
	parameter int SETUP_BYTES = `TKD_SETUP_BYTES,
	parameter int ARM_CYCLES = `TKD_ARM_WINDOW_MS * `TKD_CLK_KHZ
) (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic sclk, // Serial clock pin from the host.
	input wire logic csN, // Chip select pin, active low.
	input wire logic mosi, // Serial data from the host.
	output logic miso, // Serial data to the host.
	output logic misoOe, // High while the device drives miso.
	input wire logic [NKEYS-1:0] keyDetect, // Key in detect.
	input wire logic [NKEYS-1:0] keyEnabled, // Key enabled.
	input wire logic [NKEYS-1:0] keyLowSig, // Reference below low_signal_limit.
	input wire logic [NKEYS-1:0] keyCal, // Key calibrating.
	input wire logic [NKEYS-1:0] keyCalFail, // Calibration failed five times.
	input wire logic [NKEYS*16-1:0] keySignal, // Signal per key.
	input wire logic [NKEYS*16-1:0] keyRef, // Reference per key.
	input wire logic [NKEYS*8-1:0] keyNdi, // normal_detect_integrator_count per key.
	input wire logic syncFail, // Sync failure.
	input wire logic [7:0] lineSelfTest, // line_self_test failures on X, Y lines.
	input wire logic slotStrobe, // Start of a key's scan timeslot.
	input wire logic [4:0] slotKey, // Key whose timeslot starts.
	input wire logic setupWrEn, // Setups loader write strobe.
	input wire logic [6:0] setupWrAddr, // Setups loader address.
	input wire logic [7:0] setupWrData, // Setups loader data.
	output logic calAllGo, // Pulse: recalibrate every key.
	output logic resetGo, // Pulse: perform device reset.
	output logic calKeyGo, // Pulse: recalibrate calKeyIdx now.
	output logic [4:0] calKeyIdx, // Key of the single-key recalibration.
	output logic scanHalt, // Key scanning halted.
	output logic commsError // Unknown command seen.
);

	logic sclkMeta_q, sclkS_q, sclkPrev_q, csMeta_q, csS_q, csPrev_q, mosiMeta_q, mosiS_q;
	logic [2:0] bitCnt_q;
	logic [7:0] rxShift_q, txShift_q, rxByte_q, lastCmd_q, crc_q, armByte_q, eeCrc_q;
	logic [7:0] sweepCrc_q, memDataA, memDataB, dataByte, txNext, crcSeed, crcNext;
	logic [7:0] statusByte, firstByte, keyStatus;
	logic byteDone, stepNow, step_q, armed_q, resetPend_q, calKeyPend_q, sweepLive_q;
	logic isNull, isDouble, unknown, exec, isCrcByte, isDataByte, responding, keyOk;
	logic [4:0] key_q, selKey;
	logic [6:0] idx_q, left_q, selIdx, len, total, memAddr, sweepAddr_q, sweepPrev_q;
	logic [22:0] armCnt_q;
	logic [23:0] detField, errField;
	tkd_rsp_type kind_q, newKind, selKind;
	logic [NKEYS-1:0] detEn;

	// Pins cross into clk through two flops; the first stage is never looked at, and a third flop on sclk and csN marks edges.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{sclkMeta_q, sclkS_q, sclkPrev_q} <= 3'h0;
			{csMeta_q, csS_q, csPrev_q} <= 3'h7;
			{mosiMeta_q, mosiS_q} <= 2'h0;
		end else begin
			{sclkMeta_q, sclkS_q, sclkPrev_q} <= {sclk, sclkMeta_q, sclkS_q};
			{csMeta_q, csS_q, csPrev_q} <= {csN, csMeta_q, csS_q};
			{mosiMeta_q, mosiS_q} <= {mosi, mosiMeta_q};
		end
	end

	assign byteDone = !csS_q && sclkS_q && !sclkPrev_q && (bitCnt_q == 3'h7);

	// Shift register: sample on rising, present on falling, load one cycle after a byte.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bitCnt_q <= 3'h0;
			rxShift_q <= 8'h00;
			txShift_q <= 8'h00;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			misoOe <= !csS_q;
			if (csS_q) begin
				bitCnt_q <= 3'h0;
			end else if (csPrev_q || (!sclkS_q && sclkPrev_q)) begin
				miso <= txShift_q[7];
				txShift_q <= {txShift_q[6:0], 1'b0};
			end else if (sclkS_q && !sclkPrev_q) begin
				rxShift_q <= {rxShift_q[6:0], mosiS_q};
				bitCnt_q <= bitCnt_q + 3'h1;
			end else if (stepNow) begin
				txShift_q <= txNext;
			end
		end
	end

	// The byte is latched on its last edge and decoded a cycle later, once memory has answered.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			step_q <= 1'b0;
			rxByte_q <= 8'h00;
		end else begin
			step_q <= byteDone;
			if (byteDone) begin
				rxByte_q <= {rxShift_q[6:0], mosiS_q};
			end
		end
	end
	assign stepNow = step_q;

	// Key summaries shared by several replies.
	always_comb begin
		detEn = keyDetect & keyEnabled;
		detField = 24'(detEn);
		errField = 24'((keyCalFail | keyLowSig) & keyEnabled);
		statusByte = 8'h00;
		statusByte[`TKD_ST_CAL] = |keyCal;
		statusByte[`TKD_ST_CALFAIL] = |(keyCalFail & keyEnabled);
		statusByte[`TKD_ST_SYNC] = syncFail;
		statusByte[`TKD_ST_SELFTEST] = |lineSelfTest;
		statusByte[`TKD_ST_LOWSIG] = |(keyLowSig & keyEnabled);
		statusByte[`TKD_ST_COMMS] = commsError;
		firstByte = {3'h0, `TKD_NO_KEY};
		for (int i = NKEYS - 1; i >= 0; i--) begin
			if (detEn[i]) begin
				firstByte[4:0] = 5'(i);
			end
		end
		firstByte[`TKD_FK_MULTI] = |(detEn & (detEn - NKEYS'(1)));
		firstByte[`TKD_FK_ERROR] = statusByte[`TKD_ST_CAL] | statusByte[`TKD_ST_CALFAIL]
			| syncFail | commsError | statusByte[`TKD_ST_SELFTEST];
	end

	// Command decode of the byte just received.
	always_comb begin
		isNull = (rxByte_q == `TKD_CMD_NULL);
		keyOk = (int'(rxByte_q[5:0]) < NKEYS);
		isDouble = 1'b0;
		unknown = 1'b0;
		newKind = RK_IDLE;
		unique case (rxByte_q[7:6])
			`TKD_GRP_PLAIN: begin
				unique case (rxByte_q)
					`TKD_CMD_NULL: newKind = RK_IDLE;
					`TKD_CMD_CALALL, `TKD_CMD_RESET: isDouble = 1'b1;
					`TKD_CMD_STATUS: newKind = RK_STATUS;
					`TKD_CMD_FIRST: newKind = RK_FIRST;
					`TKD_CMD_ALLKEYS: newKind = RK_ALL;
					`TKD_CMD_ERRALL: newKind = RK_ERR;
					`TKD_CMD_SELFTEST: newKind = RK_SELF;
					`TKD_CMD_DUMP: newKind = RK_DUMP;
					`TKD_CMD_EECRC: newKind = RK_EECRC;
					`TKD_CMD_LAST: newKind = RK_LAST;
					default: unknown = 1'b1;
				endcase
			end
			`TKD_GRP_DIAG: begin
				newKind = keyOk ? RK_DIAG : RK_IDLE;
				unknown = !keyOk;
			end
			`TKD_GRP_KEYST: begin
				newKind = keyOk ? RK_KEYST : RK_IDLE;
				unknown = !keyOk;
			end
			`TKD_GRP_CALKEY: begin
				isDouble = keyOk;
				unknown = !keyOk;
			end
		endcase
		// only an armed matching copy executes
		exec = isDouble && armed_q && (armByte_q == rxByte_q);
		if (exec) begin
			newKind = RK_ACK;
		end
	end

	// Reply byte for the current kind and index.
	always_comb begin
		selKind = isNull ? kind_q : newKind;
		selIdx = isNull ? idx_q : 7'h00;
		selKey = isNull ? key_q : rxByte_q[4:0];
		keyStatus = 8'h00;
		keyStatus[`TKD_KS_ENABLED] = keyEnabled[selKey];
		keyStatus[`TKD_KS_DETECT] = detEn[selKey];
		keyStatus[`TKD_KS_LOWSIG] = keyLowSig[selKey];
		keyStatus[`TKD_KS_CAL] = keyCal[selKey];
		keyStatus[`TKD_KS_CALFAIL] = keyCalFail[selKey];
		len = 7'h00;
		dataByte = 8'h00;
		unique case (selKind)
			RK_IDLE: len = 7'h00;
			RK_ACK: begin
				len = `TKD_ONE_BYTE;
				dataByte = ~rxByte_q;
			end
			RK_STATUS: begin
				len = `TKD_ONE_BYTE;
				dataByte = statusByte;
			end
			RK_FIRST: begin
				len = `TKD_ONE_BYTE;
				dataByte = firstByte;
			end
			RK_ALL: begin
				len = `TKD_FIELD_BYTES;
				dataByte = 8'(detField >> {selIdx[1:0], 3'h0});
			end
			RK_ERR: begin
				len = `TKD_FIELD_BYTES;
				dataByte = 8'(errField >> {selIdx[1:0], 3'h0});
			end
			RK_SELF: begin
				len = `TKD_ONE_BYTE;
				dataByte = lineSelfTest;
			end
			RK_DUMP: begin
				len = 7'(SETUP_BYTES);
				dataByte = memDataA;
			end
			RK_EECRC: begin
				len = `TKD_ONE_BYTE;
				dataByte = eeCrc_q;
			end
			RK_LAST: begin
				len = `TKD_ONE_BYTE;
				dataByte = ~lastCmd_q;
			end
			RK_DIAG: begin
				len = `TKD_DIAG_BYTES;
				unique case (selIdx[2:0])
					3'h0: dataByte = keySignal[{selKey, 4'h0} +: 8];
					3'h1: dataByte = keySignal[{selKey, 4'h8} +: 8];
					3'h2: dataByte = keyRef[{selKey, 4'h0} +: 8];
					3'h3: dataByte = keyRef[{selKey, 4'h8} +: 8];
					default: dataByte = keyNdi[{selKey, 3'h0} +: 8];
				endcase
			end
			RK_KEYST: begin
				len = `TKD_ONE_BYTE;
				dataByte = keyStatus;
			end
		endcase
		// no checksum on acknowledgements, last byte and diagnostics
		total = len + ((selKind == RK_IDLE || selKind == RK_ACK || selKind == RK_LAST
			|| selKind == RK_DIAG) ? 7'h00 : 7'h01);
		isDataByte = (selIdx < len);
		isCrcByte = !isDataByte && (selIdx < total);
		responding = !isNull || (left_q != 7'h00);
		crcSeed = isNull ? crc_q : tkd_crc8(`TKD_CRC_INIT, rxByte_q);
		crcNext = isDataByte ? tkd_crc8(crcSeed, dataByte) : crcSeed;
		// trailing CRC over command and data
		txNext = !responding ? `TKD_CMD_NULL : (isCrcByte ? crcSeed : dataByte);
	end

	// Reply progress: a new command abandons what is pending.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			kind_q <= RK_IDLE;
			{idx_q, left_q} <= 14'h0000;
			{lastCmd_q, crc_q} <= 16'h0000;
			key_q <= 5'h00;
		end else if (stepNow && !isNull) begin
			kind_q <= newKind;
			key_q <= rxByte_q[4:0];
			lastCmd_q <= rxByte_q;
			idx_q <= (total != 7'h00) ? 7'h01 : 7'h00;
			left_q <= (total != 7'h00) ? total - 7'h01 : 7'h00;
			crc_q <= crcNext;
		// each null byte pulls one reply byte
		end else if (stepNow && left_q != 7'h00) begin
			idx_q <= (left_q == 7'h01) ? 7'h00 : idx_q + 7'h01;
			left_q <= left_q - 7'h01;
			crc_q <= crcNext;
		end
	end

	// Guard window for the second copy of a guarded command.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			armed_q <= 1'b0;
			armByte_q <= 8'h00;
			armCnt_q <= 23'h00_0000;
		end else if (stepNow && !isNull) begin
			armed_q <= isDouble && !exec;
			armByte_q <= rxByte_q;
			armCnt_q <= 23'h00_0000;
		end else if (armed_q) begin
			armed_q <= (armCnt_q != 23'(ARM_CYCLES - 1));
			armCnt_q <= armCnt_q + 23'h00_0001;
		end
	end

	// Actions of executed commands.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{calAllGo, resetGo, calKeyGo, resetPend_q, calKeyPend_q} <= 5'h00;
			calKeyIdx <= 5'h00;
		end else begin
			// recalibrate all, sensing resumes by itself
			calAllGo <= stepNow && exec && (rxByte_q == `TKD_CMD_CALALL);
			// reset only after the acknowledgement byte went out
			resetGo <= resetPend_q && byteDone;
			if (stepNow && exec && (rxByte_q == `TKD_CMD_RESET)) begin
				resetPend_q <= 1'b1;
			end else if (byteDone) begin
				resetPend_q <= 1'b0;
			end
			// wait for the key's own timeslot
			calKeyGo <= calKeyPend_q && slotStrobe && (slotKey == calKeyIdx);
			if (stepNow && exec && (rxByte_q[7:6] == `TKD_GRP_CALKEY)) begin
				calKeyPend_q <= 1'b1;
				calKeyIdx <= rxByte_q[4:0];
			end else if (slotStrobe && (slotKey == calKeyIdx)) begin
				calKeyPend_q <= 1'b0;
			end
		end
	end

	// Comms error and scan halt flags.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			commsError <= 1'b0;
			scanHalt <= 1'b0;
		end else if (stepNow) begin
			// unknown code flagged, the last-command query clears the flag
			if (unknown) begin
				commsError <= 1'b1;
			end else if (rxByte_q == `TKD_CMD_LAST) begin
				commsError <= 1'b0;
			end
			// halt lasts until the checksum byte has been exchanged
			if (!isNull) begin
				scanHalt <= (newKind == RK_DUMP);
			end else if (left_q == 7'h00) begin
				scanHalt <= 1'b0;
			end
		end
	end

	// Memory must be addressed in the byte's last cycle so data is ready at decode.
	assign memAddr = (byteDone && ({rxShift_q[6:0], mosiS_q} != `TKD_CMD_NULL)) ? 7'h00 : idx_q;

	tkd_setup_mem #(.DEPTH(SETUP_BYTES), .AW(7)) setupMem (
		.clk(clk),
		.wrEn(setupWrEn),
		.wrAddr(setupWrAddr),
		.wrData(setupWrData),
		.rdAddrA(memAddr),
		.rdDataA(memDataA),
		.rdAddrB(sweepAddr_q),
		.rdDataB(memDataB)
	);

	// background checksum over the setup array only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{sweepAddr_q, sweepPrev_q} <= 14'h0000;
			sweepLive_q <= 1'b0;
			{sweepCrc_q, eeCrc_q} <= 16'h0000;
		end else begin
			sweepLive_q <= 1'b1;
			sweepPrev_q <= sweepAddr_q;
			sweepAddr_q <= (sweepAddr_q == 7'(SETUP_BYTES - 1)) ? 7'h00 : sweepAddr_q + 7'h01;
			if (sweepLive_q) begin
				sweepCrc_q <= tkd_crc8((sweepPrev_q == 7'h00) ? `TKD_CRC_INIT : sweepCrc_q, memDataB);
				if (sweepPrev_q == 7'(SETUP_BYTES - 1)) begin
					eeCrc_q <= tkd_crc8(sweepCrc_q, memDataB);
				end
			end
		end
	end

	sequence s_exec(logic [7:0] code);
		stepNow && exec && rxByte_q == code;
	endsequence
	sequence s_ackLoaded(logic [7:0] ack);
		##1 txShift_q == ack;
	endsequence
	property p_calAllAck;
		@(posedge clk) disable iff (reset) s_exec(`TKD_CMD_CALALL) |-> s_ackLoaded(8'hFC) ##0 calAllGo;
	endproperty
	a_calAllAck: assert property (p_calAllAck) else $error("Recalibrate-all ack wrong.");
	property p_resetAck;
		@(posedge clk) disable iff (reset) s_exec(`TKD_CMD_RESET) |-> s_ackLoaded(8'hFB) ##0 !resetGo;
	endproperty
	a_resetAck: assert property (p_resetAck) else $error("Reset fired before its ack.");
	property p_expire;
		@(posedge clk) disable iff (reset)
			armed_q && !stepNow && armCnt_q == 23'(ARM_CYCLES - 1) |=> !armed_q;
	endproperty
	a_expire: assert property (p_expire) else $error("Guard window did not close.");
	property p_firstCopy;
		@(posedge clk) disable iff (reset) stepNow && isDouble && !armed_q |=> armed_q && !calAllGo;
	endproperty
	a_firstCopy: assert property (p_firstCopy) else $error("First copy executed.");
	property p_unknown;
		@(posedge clk) disable iff (reset) stepNow && unknown |=> commsError && txShift_q == 8'h00;
	endproperty
	a_unknown: assert property (p_unknown) else $error("Unknown code not flagged.");
	property p_lastClears;
		@(posedge clk) disable iff (reset)
			stepNow && rxByte_q == `TKD_CMD_LAST |=> !commsError && txShift_q == ~$past(lastCmd_q);
	endproperty
	a_lastClears: assert property (p_lastClears) else $error("Last query wrong.");
	property p_noTouch;
		@(posedge clk) disable iff (reset) detEn == '0 |-> firstByte[4:0] == `TKD_NO_KEY;
	endproperty
	a_noTouch: assert property (p_noTouch) else $error("No-touch code wrong.");
	property p_multi;
		@(posedge clk) disable iff (reset) $countones(detEn) > 1 |-> firstByte[`TKD_FK_MULTI];
	endproperty
	a_multi: assert property (p_multi) else $error("Multi-touch flag missing.");
	property p_dumpHalt;
		@(posedge clk) disable iff (reset)
			stepNow && !isNull && newKind == RK_DUMP |=> scanHalt && left_q == 7'(SETUP_BYTES);
	endproperty
	a_dumpHalt: assert property (p_dumpHalt) else $error("Dump did not halt scanning.");
	property p_diagLen;
		@(posedge clk) disable iff (reset) stepNow && !isNull && newKind == RK_DIAG |=> left_q == 7'h04;
	endproperty
	a_diagLen: assert property (p_diagLen) else $error("Diagnostic length wrong.");
	property p_slot;
		@(posedge clk) disable iff (reset) calKeyGo |-> $past(slotStrobe) && $past(slotKey) == calKeyIdx;
	endproperty
	a_slot: assert property (p_slot) else $error("Key recalibrated outside its slot.");

endmodule // tkd_decoder

// ### tb/tkd_host.sv
// Purpose: Host model that clocks the serial port in mode 0.
// Assumes: It steps on falling clk edges, four clk per half sclk period.
// Notes: The select stays low between bytes, so replies keep flowing.
module tkd_host (
	input wire logic clk, // System clock.
	output logic sclk, // Serial clock, idles low.
	output logic csN, // Chip select, active low.
	output logic mosi, // Data to the device.
	input wire logic miso // Data from the device.
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle the link; the clock stands still outside frames.
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		csN = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			repeat (4) @(negedge clk);
			sclk = 1'b1; // Device data is read at the rising edge.
			rx[i] = miso;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
	endtask
endmodule // tkd_host

// ### tb/touch_key_host_command_decoder_tb.sv
// Purpose: Self-checking bench of the command decoder.
// Assumes: A short guard window keeps the run brief.
// Notes: Field bytes repeat one pattern, since the order of the three bytes is left open.
`include "tkd_consts.svh"
module touch_key_host_command_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ARM = 2000;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic sclk, csN, mosi, miso, misoOe, calAllGo, resetGo, calKeyGo, scanHalt, commsError;
	logic syncFail = 1'b0;
	logic setupWrEn = 1'b0;
	logic [6:0] setupWrAddr = 7'h00;
	logic [7:0] lineSelfTest = 8'h00, setupWrData = 8'h00;
	logic slotStrobe = 1'b0;
	logic [4:0] slotKey = 5'h00;
	logic [4:0] calKeyIdx, lastIdx;
	logic [23:0] keyDetect = '0, keyCal = '0, keyLowSig = '0, keyCalFail = '0, keyEnabled = '1;
	logic [383:0] keySignal = '0, keyRef = '0;
	logic [191:0] keyNdi = '0;
	logic [7:0] rsp [0:5];
	int num_errors = 0, n_compared = 0, nCal = 0, nRst = 0, nKey = 0;
	always #10 clk = ~clk;
	// Count the one-cycle command pulses.
	always @(posedge clk) begin
		nCal += (calAllGo === 1'b1);
		nRst += (resetGo === 1'b1);
		if (calKeyGo === 1'b1) begin
			nKey++;
			lastIdx = calKeyIdx;
		end
	end
	tkd_host host (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
	tkd_decoder #(.ARM_CYCLES(ARM)) DUT (.clk(clk), .reset(reset), .sclk(sclk), .csN(csN),
		.mosi(mosi), .miso(miso), .misoOe(misoOe), .keyDetect(keyDetect),
		.keyEnabled(keyEnabled), .keyLowSig(keyLowSig), .keyCal(keyCal),
		.keyCalFail(keyCalFail), .keySignal(keySignal), .keyRef(keyRef), .keyNdi(keyNdi),
		.syncFail(syncFail), .lineSelfTest(lineSelfTest), .slotStrobe(slotStrobe),
		.slotKey(slotKey), .setupWrEn(setupWrEn), .setupWrAddr(setupWrAddr),
		.setupWrData(setupWrData),
		.calAllGo(calAllGo), .resetGo(resetGo), .calKeyGo(calKeyGo),
		.calKeyIdx(calKeyIdx), .scanHalt(scanHalt), .commsError(commsError));
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		c ^= d;
		repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ `TKD_CRC_POLY) : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Send a command, then n nulls whose replies land in rsp.
	task automatic run(input logic [7:0] c, input int n);
		logic [7:0] r;
		host.xfer(c, r);
		for (int i = 0; i < n; i++) host.xfer(8'h00, rsp[i]);
	endtask
	task automatic t_status();
		run(8'h02, 0);
		chk("oe", misoOe, 8'h01);
		chk("commsError", commsError, 8'h01);
		run(8'h05, 2);
		chk("status", rsp[0], 8'h40);
		chk("statusCrc", rsp[1], crc(crc(8'h00, 8'h05), 8'h40));
		run(8'h0F, 1);
		chk("last", rsp[0], 8'hFA);
		chk("commsClear", commsError, 8'h00);
	endtask
	task automatic t_first();
		keyDetect = 24'h00_0208;
		syncFail = 1'b1;
		run(8'h06, 2);
		chk("first", rsp[0], 8'hC3);
		chk("firstCrc", rsp[1], crc(crc(8'h00, 8'h06), 8'hC3));
		keyDetect = '0;
		syncFail = 1'b0;
		run(8'h06, 1);
		chk("noKey", rsp[0], {3'h0, `TKD_NO_KEY});
	endtask
	// Detect and error fields share one pattern and one loop.
	task automatic t_fields();
		logic [7:0] c, e;
		keyDetect = 24'h81_8181;
		keyLowSig = 24'h81_8181;
		for (int k = 0; k < 2; k++) begin
			c = k ? 8'h0B : 8'h07;
			e = crc(8'h00, c);
			run(c, 4);
			for (int i = 0; i < 3; i++) begin
				chk("field", rsp[i], 8'h81);
				e = crc(e, 8'h81);
			end
			chk("fieldCrc", rsp[3], e);
		end
		keyDetect = '0;
		keyLowSig = '0;
	endtask
	task automatic t_key();
		keySignal[80+:16] = 16'h1234;
		keyRef[80+:16] = 16'hABCD;
		keyNdi[40+:8] = 8'h5A;
		run(8'h45, 5);
		chk("sigLo", rsp[0], 8'h34);
		chk("sigHi", rsp[1], 8'h12);
		chk("refLo", rsp[2], 8'hCD);
		chk("refHi", rsp[3], 8'hAB);
		chk("ndi", rsp[4], 8'h5A);
		keyEnabled[6] = 1'b0; // A disabled key must not show its detect.
		{keyDetect[6], keyLowSig[6], keyCal[6], keyCalFail[6]} = 4'hF;
		run(8'h86, 2);
		chk("keySt", rsp[0], 8'h07);
		chk("keyStCrc", rsp[1], crc(crc(8'h00, 8'h86), 8'h07));
	endtask
	task automatic t_guard();
		run(8'h03, 0);
		run(8'h03, 1);
		chk("calAck", rsp[0], 8'hFC);
		chk("calGo", nCal[7:0], 8'h01);
		run(8'h03, 0);
		repeat (ARM + 100) @(negedge clk);
		run(8'h03, 1);
		chk("expired", rsp[0], 8'h00);
		chk("noCal", nCal[7:0], 8'h01);
		run(8'h03, 1);
		chk("reissue", rsp[0], 8'hFC);
		run(8'h04, 0);
		run(8'h04, 1);
		repeat (4) @(negedge clk);
		chk("rstAck", rsp[0], 8'hFB);
		chk("rstGo", nRst[7:0], 8'h01);
		run(8'hC5, 0);
		run(8'hC5, 1);
		chk("keyAck", rsp[0], 8'h3A);
		for (int s = 4; s < 6; s++) begin
			slotKey = s[4:0];
			slotStrobe = 1'b1;
			@(negedge clk) slotStrobe = 1'b0;
			repeat (3) @(negedge clk);
			chk("keyGo", nKey[7:0], 8'(s - 4));
		end
		chk("keyIdx", lastIdx, 8'h05);
	endtask
	// Setup array: self-test byte, stored checksum, then the dump and its scan halt.
	task automatic t_setup();
		logic [7:0] r, e;
		lineSelfTest = 8'h21;
		run(8'h0C, 2);
		chk("selfTest", rsp[0], 8'h21);
		chk("selfTestCrc", rsp[1], crc(crc(8'h00, 8'h0C), 8'h21));
		lineSelfTest = 8'h00;
		for (int i = 0; i < `TKD_SETUP_BYTES; i++) begin
			setupWrAddr = 7'(i);
			setupWrData = 8'(i) ^ 8'hA5;
			setupWrEn = 1'b1;
			@(negedge clk);
		end
		setupWrEn = 1'b0;
		// Two full sweeps of the array are enough for the stored checksum to settle.
		repeat (250) @(negedge clk);
		e = 8'h00;
		for (int i = 0; i < `TKD_SETUP_BYTES; i++) e = crc(e, 8'(i) ^ 8'hA5);
		run(8'h0E, 2);
		chk("eeCrc", rsp[0], e);
		chk("eeCrcCrc", rsp[1], crc(crc(8'h00, 8'h0E), e));
		run(8'h0D, 0);
		chk("halt", scanHalt, 8'h01);
		e = crc(8'h00, 8'h0D);
		for (int i = 0; i <= `TKD_SETUP_BYTES; i++) begin
			host.xfer(8'h00, r);
			chk("dump", r, (i < `TKD_SETUP_BYTES) ? 8'(i) ^ 8'hA5 : e);
			e = crc(e, 8'(i) ^ 8'hA5);
		end
		chk("resume", scanHalt, 8'h00);
	endtask
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Cut a hang short well beyond the expected run time.
	initial begin
		#500000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (5) @(negedge clk);
		chk("oeIdle", misoOe, 8'h00);
		t_status();
		t_first();
		t_fields();
		t_key();
		t_setup();
		t_guard();
		give_verdict();
	end
endmodule // touch_key_host_command_decoder_tb
